// ===== logic/tw_pkg.sv
// Shared constants for the two-wire target port and its bus master
// Assumes both ends run on one 50 MHz clock with synchronous reset
`default_nettype none
package tw_pkg;
   // ----------------------------------------
   // Identity and framing
   // ----------------------------------------
   localparam logic [5:0] ID_FIXED = 6'h0C;   // Upper six bits 001100
   localparam int BYTE_BITS = 8;
   localparam logic [7:0] PTR_RESET = 8'h00;
   localparam logic [7:0] DATA_RESET = 8'h00;
   localparam int NUM_REGS = 16;
   localparam logic [3:0] ACCEL_FIRST = 4'h6;  // First acceleration reg
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_MHZ = 50;
   localparam int QUARTER_NS = 1250;           // Quarter bit of 200 kHz
   localparam int QUARTER_CYC = (QUARTER_NS * CLK_MHZ) / 1000;
   localparam int CONV_NS = 4000;              // Stall beyond half a bit
   localparam int CONV_CYC = (CONV_NS * CLK_MHZ + 999) / 1000;
   typedef logic [7:0] byte_t;
endpackage : tw_pkg
`default_nettype wire

// ===== logic/tw_bus_if.sv
// Two-wire bus joining the device end and the master end
// Open drain: a line is low when any party enables its low drive
`default_nettype none
interface tw_bus_if;
   logic scl_o_m, scl_oe_m, sda_o_m, sda_oe_m;
   logic scl_o_d, scl_oe_d, sda_o_d, sda_oe_d;
   // Wired-AND resolution with pull-ups
   wire logic scl = !((scl_oe_m && !scl_o_m) || (scl_oe_d && !scl_o_d));
   wire logic sda = !((sda_oe_m && !sda_o_m) || (sda_oe_d && !sda_o_d));
   modport device (input scl, input sda, output scl_o_d, output scl_oe_d,
      output sda_o_d, output sda_oe_d);
   modport master (input scl, input sda, output scl_o_m, output scl_oe_m,
      output sda_o_m, output sda_oe_m);
endinterface : tw_bus_if
`default_nettype wire

// ===== logic/tw_target.sv
// Two-wire target port of a tri-axis accelerometer
// Assumes bus lines sampled synchronously to clk, bus slow versus clk
//
// Operation
// - Target only; never drives clock edges
// - May hold clock low; master waits
// - Bytes of eight bits, MSB first, unlimited
// - Busy from start until stop
// - Start is data fall, clock high
// - First byte: seven-bit id plus direction
// - Selected only when all seven bits match
// - Id is 001100 plus strap bit
// - Receiver holds data low during acknowledge
// - Addressed receiver acknowledges every byte
// - Stop is data rise, clock high
// - Pointer byte, then data, auto-increment
// - Repeated start then read header reads
// - Stall for conversion only when enabled
// - Disabled device ignores the bus
`default_nettype none
module tw_target (
   input wire logic clk,
   input wire logic nrst,
   tw_bus_if.device bus,
   input wire logic addr_strap,
   input wire logic dev_enable,
   input wire logic stall_on_conversion,
   input wire logic [7:0] accel_sample,
   output logic bus_busy,
   output logic selected,
   output logic wr_strobe,
   output logic [3:0] wr_index,
   output logic [7:0] wr_data
);
   import tw_pkg::*;

   typedef enum {ST_IDLE, ST_HDR, ST_HDR_ACK, ST_PTR, ST_PTR_ACK, ST_WDATA,
      ST_WACK, ST_STALL, ST_RDATA, ST_RACK, ST_IGNORE} state_e;

   // ----------------------------------------
   // Line sampling and conditions
   // ----------------------------------------
   logic scl_reg, sda_reg, strap_reg;
   state_e state_reg;
   logic [3:0] cnt_reg;
   byte_t sh_reg, ptr_reg;
   logic sda_drv_reg, scl_hold_reg, rw_reg;
   logic [15:0] conv_reg;
   byte_t regs [NUM_REGS];

   wire logic scl_rise = bus.scl && !scl_reg;
   wire logic scl_fall = !bus.scl && scl_reg;
   wire logic start_c = bus.scl && scl_reg && sda_reg && !bus.sda;
   wire logic stop_c = bus.scl && scl_reg && !sda_reg && bus.sda;
   wire logic [6:0] my_id = {ID_FIXED, strap_reg};
   wire logic id_hit = sh_reg[7:1] == my_id;
   wire logic [3:0] ptr_idx = ptr_reg[3:0];
   wire logic is_accel = ptr_idx >= ACCEL_FIRST;

   always_ff @(posedge clk) begin
      scl_reg <= bus.scl;
      sda_reg <= bus.sda;
      if (!nrst) strap_reg <= 1'b0;
      else if (state_reg == ST_IDLE) strap_reg <= addr_strap;
   end

   // Free when idle, busy between start and stop
   always_ff @(posedge clk) begin
      if (!nrst || !dev_enable) bus_busy <= 1'b0;
      else if (start_c) bus_busy <= 1'b1;
      else if (stop_c) bus_busy <= 1'b0;
   end

   // ----------------------------------------
   // Protocol state machine
   // ----------------------------------------
   always_ff @(posedge clk) begin
      wr_strobe <= 1'b0;
      if (!nrst || !dev_enable) begin
         state_reg <= ST_IDLE;
         cnt_reg <= 4'h0;
         sh_reg <= DATA_RESET;
         ptr_reg <= PTR_RESET;
         sda_drv_reg <= 1'b0;
         scl_hold_reg <= 1'b0;
         rw_reg <= 1'b0;
         conv_reg <= 16'h0000;
         selected <= 1'b0;
         wr_index <= 4'h0;
         wr_data <= DATA_RESET;
         for (int i = 0; i < NUM_REGS; i++) regs[i] <= DATA_RESET;
      end else if (start_c) begin                // Start or repeated start
         state_reg <= ST_HDR;
         cnt_reg <= 4'h0;
         sda_drv_reg <= 1'b0;
         selected <= 1'b0;
      end else if (stop_c) begin
         state_reg <= ST_IDLE;
         sda_drv_reg <= 1'b0;
         scl_hold_reg <= 1'b0;
         selected <= 1'b0;
      end else begin
         regs[ACCEL_FIRST] <= accel_sample;
         case (state_reg)
            ST_HDR, ST_PTR, ST_WDATA: begin
               if (scl_rise) begin
                  sh_reg <= {sh_reg[6:0], bus.sda};
                  cnt_reg <= cnt_reg + 4'h1;
               end
               if (scl_fall && cnt_reg == 4'(BYTE_BITS)) begin
                  cnt_reg <= 4'h0;
                  if (state_reg == ST_HDR && !id_hit) begin
                     state_reg <= ST_IGNORE;
                  end else begin
                     sda_drv_reg <= 1'b1;
                     if (state_reg == ST_HDR) begin
                        rw_reg <= sh_reg[0];
                        selected <= 1'b1;
                        state_reg <= ST_HDR_ACK;
                     end else if (state_reg == ST_PTR) begin
                        ptr_reg <= {1'b0, sh_reg[6:0]};
                        state_reg <= ST_PTR_ACK;
                     end else begin
                        regs[ptr_idx] <= sh_reg;
                        wr_strobe <= 1'b1;
                        wr_index <= ptr_idx;
                        wr_data <= sh_reg;
                        state_reg <= ST_WACK;
                     end
                  end
               end
            end
            ST_HDR_ACK, ST_PTR_ACK, ST_WACK: begin
               if (scl_fall) begin
                  sda_drv_reg <= 1'b0;
                  if (state_reg == ST_WACK)
                     ptr_reg <= ptr_reg + 8'h01;
                  if (state_reg == ST_HDR_ACK && rw_reg) begin
                     if (stall_on_conversion && is_accel) begin
                        scl_hold_reg <= 1'b1;
                        conv_reg <= 16'(CONV_CYC);
                        state_reg <= ST_STALL;
                     end else begin
                        sh_reg <= regs[ptr_idx];
                        sda_drv_reg <= !regs[ptr_idx][7];
                        cnt_reg <= 4'h1;
                        state_reg <= ST_RDATA;
                     end
                  end else if (state_reg == ST_HDR_ACK) begin
                     state_reg <= ST_PTR;
                  end else begin
                     state_reg <= ST_WDATA;
                  end
               end
            end
            ST_STALL: begin                 // Hold clock during conversion
               conv_reg <= conv_reg - 16'h0001;
               if (conv_reg == 16'h0001) begin   // Data set before release
                  sh_reg <= regs[ptr_idx];
                  sda_drv_reg <= !regs[ptr_idx][7];
                  cnt_reg <= 4'h1;
               end
               if (conv_reg == 16'h0000) begin
                  conv_reg <= 16'h0000;
                  scl_hold_reg <= 1'b0;
                  state_reg <= ST_RDATA;
               end
            end
            ST_RDATA: begin                          // Shift out MSB first
               if (scl_fall) begin
                  if (cnt_reg == 4'(BYTE_BITS)) begin
                     sda_drv_reg <= 1'b0;             // Release for ack
                     ptr_reg <= ptr_reg + 8'h01;
                     state_reg <= ST_RACK;
                  end else begin
                     sda_drv_reg <= !sh_reg[6];
                     sh_reg <= {sh_reg[6:0], 1'b0};
                     cnt_reg <= cnt_reg + 4'h1;
                  end
               end
            end
            ST_RACK: begin
               if (scl_rise) begin
                  if (bus.sda) state_reg <= ST_IGNORE;  // Nack ends read
                  else cnt_reg <= 4'h0;
               end
               if (scl_fall) begin
                  sh_reg <= regs[ptr_idx];
                  sda_drv_reg <= !regs[ptr_idx][7];
                  cnt_reg <= 4'h1;
                  state_reg <= ST_RDATA;
               end
            end
            ST_IGNORE, ST_IDLE: sda_drv_reg <= 1'b0;
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // Open-drain drive: low only, never clock edges
   // ----------------------------------------
   assign bus.sda_o_d = 1'b0;
   assign bus.sda_oe_d = sda_drv_reg;
   assign bus.scl_o_d = 1'b0;
   assign bus.scl_oe_d = scl_hold_reg;
endmodule : tw_target
`default_nettype wire

// ===== logic/tw_master.sv
// Bus master end for the two-wire target port
// Assumes one transaction command at a time; clock stretch honoured
`default_nettype none
module tw_master (
   input wire logic clk,
   input wire logic nrst,
   tw_bus_if.master bus,
   input wire logic cmd_valid,
   input wire logic cmd_read,
   input wire logic [6:0] cmd_id,
   input wire logic [7:0] cmd_ptr,
   input wire logic [7:0] cmd_wdata,
   input wire logic [3:0] cmd_count,
   output logic cmd_ready,
   output logic rd_valid,
   output logic [7:0] rd_data,
   output logic nack_seen
);
   import tw_pkg::*;

   typedef enum {M_IDLE, M_START, M_BYTE, M_ACK, M_RSTART, M_STOP} mstate_e;

   // ----------------------------------------
   // Quarter-bit timing and sequencing
   // ----------------------------------------
   mstate_e st_reg;
   logic [1:0] ph_reg;
   logic [15:0] tq_reg;
   logic [3:0] bit_reg, left_reg;
   logic [2:0] step_reg;  // 0 hdr, 1 ptr, 2 data, 3 read hdr, 4 read
   byte_t tx_reg, rx_reg, wd_reg, ptr_reg;
   logic [6:0] id_reg;
   logic rd_reg, scl_reg, sda_reg;
   wire logic tick = tq_reg == 16'h0000;
   wire logic stretch = ph_reg == 2'h2 && !bus.scl;  // Clock held
   wire logic rx_phase = step_reg == 3'h4;  // Master receives data

   always_ff @(posedge clk) begin
      rd_valid <= 1'b0;
      if (!nrst) begin
         st_reg <= M_IDLE;
         ph_reg <= 2'h0;
         tq_reg <= 16'h0000;
         bit_reg <= 4'h0;
         left_reg <= 4'h0;
         step_reg <= 3'h0;
         tx_reg <= DATA_RESET;
         rx_reg <= DATA_RESET;
         wd_reg <= DATA_RESET;
         ptr_reg <= PTR_RESET;
         id_reg <= 7'h00;
         rd_reg <= 1'b0;
         scl_reg <= 1'b1;
         sda_reg <= 1'b1;
         cmd_ready <= 1'b1;
         rd_data <= DATA_RESET;
         nack_seen <= 1'b0;
      end else if (st_reg == M_IDLE) begin
         if (cmd_valid && bus.scl && bus.sda) begin  // Bus free
            cmd_ready <= 1'b0;
            nack_seen <= 1'b0;
            rd_reg <= cmd_read;
            id_reg <= cmd_id;
            ptr_reg <= {1'b0, cmd_ptr[6:0]};   // Top bit zero
            wd_reg <= cmd_wdata;
            left_reg <= cmd_count;
            step_reg <= 3'h0;
            tq_reg <= 16'(QUARTER_CYC);
            st_reg <= M_START;
         end
      end else if (stretch) begin
         tq_reg <= 16'(QUARTER_CYC);           // Clock held by target
      end else if (!tick) begin
         tq_reg <= tq_reg - 16'h0001;
      end else begin
         tq_reg <= 16'(QUARTER_CYC);
         ph_reg <= ph_reg + 2'h1;
         case (st_reg)
            M_START, M_RSTART: begin   // Quarters: sda and scl hi, sda lo, scl lo
               ph_reg <= 2'h0;
               if (!scl_reg) begin
                  sda_reg <= 1'b1;
                  scl_reg <= 1'b1;
               end else if (sda_reg) begin
                  sda_reg <= 1'b0;
               end else begin
                  scl_reg <= 1'b0;
                  tx_reg <= {id_reg, st_reg == M_RSTART};
                  step_reg <= st_reg == M_RSTART ? 3'h3 : 3'h0;
                  bit_reg <= 4'h0;
                  st_reg <= M_BYTE;
               end
            end
            M_BYTE, M_ACK: begin     // Quarters: data, rise, sample, fall
               if (ph_reg == 2'h0) begin
                  if (st_reg == M_BYTE) begin
                     sda_reg <= rx_phase || tx_reg[7];
                  end else begin          // Ack unless last read byte
                     sda_reg <= !rx_phase || left_reg == 4'h0;
                  end
               end else if (ph_reg == 2'h1) begin
                  scl_reg <= 1'b1;
               end else if (ph_reg == 2'h2) begin
                  if (st_reg == M_BYTE) rx_reg <= {rx_reg[6:0], bus.sda};
                  else if (!rx_phase && bus.sda) nack_seen <= 1'b1;
               end else begin
                  scl_reg <= 1'b0;
                  if (st_reg == M_BYTE) begin
                     tx_reg <= {tx_reg[6:0], 1'b0};
                     if (bit_reg == 4'(BYTE_BITS - 1)) begin
                        bit_reg <= 4'h0;
                        st_reg <= M_ACK;
                        if (rx_phase) begin
                           rd_valid <= 1'b1;
                           rd_data <= rx_reg;
                           left_reg <= left_reg - 4'h1;
                        end
                     end else begin
                        bit_reg <= bit_reg + 4'h1;
                     end
                  end else if (nack_seen || (rx_phase && left_reg == 4'h0) ||
                        (step_reg == 3'h2 && left_reg == 4'h1)) begin
                     st_reg <= M_STOP;
                  end else if (step_reg == 3'h1 && rd_reg) begin
                     st_reg <= M_RSTART;
                  end else begin
                     if (step_reg == 3'h2) left_reg <= left_reg - 4'h1;
                     if (step_reg != 3'h2 && !rx_phase)
                        step_reg <= step_reg + 3'h1;
                     tx_reg <= step_reg == 3'h0 ? ptr_reg : wd_reg;
                     st_reg <= M_BYTE;
                  end
               end
            end
            M_STOP: begin          // sda lo, scl hi, sda hi
               ph_reg <= 2'h0;
               if (scl_reg == 1'b0 && sda_reg) sda_reg <= 1'b0;
               else if (!scl_reg) scl_reg <= 1'b1;
               else begin
                  sda_reg <= 1'b1;
                  cmd_ready <= 1'b1;
                  st_reg <= M_IDLE;
               end
            end
            default: st_reg <= M_IDLE;
         endcase
      end
   end

   // Open-drain outputs: enable only while pulling low
   assign bus.scl_o_m = 1'b0;
   assign bus.scl_oe_m = !scl_reg;
   assign bus.sda_o_m = 1'b0;
   assign bus.sda_oe_m = !sda_reg;
endmodule : tw_master
`default_nettype wire

// ===== test/accel_port_checker.sv
// Concurrent checks on the two-wire bus between master end and target end
// Assumes one clock domain and synchronous active-low reset nrst
`default_nettype none
module accel_port_checker (
   input wire logic clk,
   input wire logic nrst,
   input wire logic scl,
   input wire logic sda,
   input wire logic scl_o_d,
   input wire logic scl_oe_d,
   input wire logic sda_o_d,
   input wire logic sda_oe_d,
   input wire logic sda_oe_m,
   input wire logic dev_enable,
   input wire logic stall_on_conversion,
   input wire logic bus_busy,
   input wire logic selected
);
   import tw_pkg::*;
   // ----------------------------------------
   // Stall length counter
   // ----------------------------------------
   logic [7:0] stall_cnt_reg;
   logic [7:0] stall_cnt_next;
   // Count cycles the target holds the clock low
   assign stall_cnt_next = scl_oe_d ? stall_cnt_reg + 8'h01 : 8'h00;
   always_ff @(posedge clk) begin
      if (!nrst) stall_cnt_reg <= 8'h00;
      else stall_cnt_reg <= stall_cnt_next;
   end
   // ----------------------------------------
   // Bus conditions and properties
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   sequence start_seq;
      scl && $past(scl) && $fell(sda);
   endsequence
   sequence stop_seq;
      scl && $past(scl) && $rose(sda);
   endsequence
   sequence on_seq;
      dev_enable && $past(dev_enable, 4);
   endsequence
   start_busy_a: assert property (on_seq ##0 start_seq |->
      ##[1:4] bus_busy) else $error("busy not raised");
   stop_free_a: assert property ((dev_enable && $past(dev_enable, 4))
      ##0 stop_seq |-> ##[1:4] !bus_busy) else $error("busy not cleared");
   released_idle_a: assert property (!bus_busy |->
      !sda_oe_d && !scl_oe_d) else $error("target drives idle bus");
   scl_drive_a: assert property (scl_oe_d |->
      !scl_o_d && stall_on_conversion) else $error("bad clock hold");
   stall_len_a: assert property ($fell(scl_oe_d) |->
      stall_cnt_reg >= CONV_CYC && stall_cnt_reg <= CONV_CYC + 1)
      else $error("stall length wrong");
   stall_cap_a: assert property (stall_cnt_reg <= CONV_CYC + 1)
      else $error("stall too long");
   sda_drive_a: assert property (sda_oe_d |->
      !sda_o_d && selected) else $error("data driven unselected");
   sda_hold_a: assert property ((dev_enable && $past(dev_enable)
      && $changed(sda_oe_d)) |-> !scl) else $error("data moved, clock high");
   off_quiet_a: assert property ((!dev_enable && !$past(dev_enable))
      |-> !sda_oe_d && !scl_oe_d) else $error("disabled target drives");
   master_wait_a: assert property ((scl_oe_d && $past(scl_oe_d))
      |-> $stable(sda_oe_m)) else $error("master moved in stall");
endmodule // accel_port_checker
`default_nettype wire

// ===== test/tb_accel_i2c_slave_port.sv
// Self-checking bench: master end and target end joined on one bus
// Assumes the shared package, bus interface and both ends are compiled
`default_nettype none
module tb_accel_i2c_slave_port;
   timeunit 1ns;
   timeprecision 100ps;
   import tw_pkg::*;
   // ----------------------------------------
   // Signals and instances
   // ----------------------------------------
   logic clk, nrst, addr_strap, dev_enable, stall_on_conversion;
   logic bus_busy, selected, wr_strobe, cmd_valid, cmd_read;
   logic cmd_ready, rd_valid, nack_seen;
   logic [7:0] accel_sample, wr_data, cmd_ptr, cmd_wdata, rd_data;
   logic [3:0] wr_index, cmd_count;
   logic [6:0] cmd_id;
   logic [11:0] wr_q[$];
   logic [7:0] rd_q[$];
   int failures, tests_run, max_stall, stall_run;
   localparam logic [6:0] ID0 = {ID_FIXED, 1'b0};
   tw_bus_if u_tw_bus_if();
   tw_target u_tw_target(.clk(clk), .nrst(nrst), .bus(u_tw_bus_if),
      .addr_strap(addr_strap), .dev_enable(dev_enable),
      .stall_on_conversion(stall_on_conversion),
      .accel_sample(accel_sample), .bus_busy(bus_busy),
      .selected(selected), .wr_strobe(wr_strobe), .wr_index(wr_index),
      .wr_data(wr_data));
   tw_master u_tw_master(.clk(clk), .nrst(nrst), .bus(u_tw_bus_if),
      .cmd_valid(cmd_valid), .cmd_read(cmd_read), .cmd_id(cmd_id),
      .cmd_ptr(cmd_ptr), .cmd_wdata(cmd_wdata), .cmd_count(cmd_count),
      .cmd_ready(cmd_ready), .rd_valid(rd_valid), .rd_data(rd_data),
      .nack_seen(nack_seen));
   accel_port_checker u_accel_port_checker(.clk(clk), .nrst(nrst),
      .scl(u_tw_bus_if.scl), .sda(u_tw_bus_if.sda),
      .scl_o_d(u_tw_bus_if.scl_o_d), .scl_oe_d(u_tw_bus_if.scl_oe_d),
      .sda_o_d(u_tw_bus_if.sda_o_d), .sda_oe_d(u_tw_bus_if.sda_oe_d),
      .sda_oe_m(u_tw_bus_if.sda_oe_m), .dev_enable(dev_enable),
      .stall_on_conversion(stall_on_conversion), .bus_busy(bus_busy),
      .selected(selected));
   // 50 MHz clock
   initial clk = 1'b0;
   always #10 clk = ~clk;
   // Collect writes, read bytes and the longest clock hold mid-cycle
   always @(negedge clk) begin
      if (wr_strobe === 1'b1) wr_q.push_back({wr_index, wr_data});
      if (rd_valid === 1'b1) rd_q.push_back(rd_data);
      stall_run = (u_tw_bus_if.scl_oe_d === 1'b1) ? stall_run + 1 : 0;
      if (stall_run > max_stall) max_stall = stall_run;
   end
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic check(input string what, input logic [15:0] exp,
      input logic [15:0] got);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d failures %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // One whole transaction; returns with the bus free again
   task automatic run_cmd(input logic rd, input logic [6:0] id,
      input logic [7:0] ptr, input logic [7:0] wd, input logic [3:0] n);
      int k;
      k = 0;
      wr_q.delete();
      rd_q.delete();
      max_stall = 0;
      cmd_read = rd;
      cmd_id = id;
      cmd_ptr = ptr;
      cmd_wdata = wd;
      cmd_count = n;
      cmd_valid = 1'b1;
      do begin
         @(posedge clk);
         #2;
         k++;
      end while (cmd_ready === 1'b1 && k < 100);
      cmd_valid = 1'b0;
      if (cmd_ready === 1'b1) k = 40000;   // Command never taken
      while ((cmd_ready !== 1'b1 || bus_busy !== 1'b0) && k < 40000) begin
         @(posedge clk);
         #2;
         k++;
      end
      if (k >= 40000) begin
         failures++;
         wrap_up();
      end
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_write();
      run_cmd(1'b0, ID0, 8'h02, 8'h1E, 4'h3);
      check("write nack", 16'h0, 16'(nack_seen));
      check("write count", 16'h3, 16'(wr_q.size()));
      for (int i = 0; i < 3; i++)
         check("write", {4'h2 + 4'(i), 8'h1E}, wr_q[i]);
      $display("write test done");
   endtask
   task automatic t_read();
      run_cmd(1'b1, ID0, 8'h02, 8'h00, 4'h3);
      check("read nack", 16'h0, 16'(nack_seen));
      check("read count", 16'h3, 16'(rd_q.size()));
      for (int i = 0; i < 3; i++)
         check("read", 16'h1E, 16'(rd_q[i]));
      check("no write", 16'h0, 16'(wr_q.size()));
      $display("read test done");
   endtask
   task automatic t_mismatch();
      for (int b = 0; b < 7; b++) begin
         run_cmd(1'b0, ID0 ^ (7'h01 << b), 8'h02, 8'hFF, 4'h1);
         check("miss nack", 16'h1, 16'(nack_seen));
         check("miss write", 16'h0, 16'(wr_q.size()));
      end
      $display("mismatch test done");
   endtask
   task automatic t_strap();
      addr_strap = 1'b1;
      repeat (4) @(posedge clk);
      #2;
      run_cmd(1'b0, {ID_FIXED, 1'b1}, 8'h09, 8'hC3, 4'h1);
      check("strap nack", 16'h0, 16'(nack_seen));
      check("strap write", 16'h9C3, 16'(wr_q[0]));
      run_cmd(1'b0, ID0, 8'h09, 8'hC3, 4'h1);
      check("strap miss", 16'h1, 16'(nack_seen));
      addr_strap = 1'b0;
      $display("strap test done");
   endtask
   task automatic t_disable();
      dev_enable = 1'b0;
      run_cmd(1'b0, ID0, 8'h02, 8'h55, 4'h1);
      check("off nack", 16'h1, 16'(nack_seen));
      check("off write", 16'h0, 16'(wr_q.size()));
      dev_enable = 1'b1;
      $display("disable test done");
   endtask
   task automatic t_stall();
      run_cmd(1'b1, ID0, 8'h06, 8'h00, 4'h1);
      check("sample", 16'h5A, 16'(rd_q[0]));
      check("no stall", 16'h0, 16'(max_stall));
      stall_on_conversion = 1'b1;
      run_cmd(1'b1, ID0, 8'h06, 8'h00, 4'h1);
      check("stall sample", 16'h5A, 16'(rd_q[0]));
      check("stall min", 16'h1, 16'(max_stall >= CONV_CYC));
      check("stall max", 16'h1, 16'(max_stall <= CONV_CYC + 1));
      stall_on_conversion = 1'b0;
      $display("stall test done");
   endtask
   // Reset, then every scenario in turn
   initial begin
      nrst = 1'b0;
      addr_strap = 1'b0;
      dev_enable = 1'b1;
      stall_on_conversion = 1'b0;
      accel_sample = 8'h5A;
      cmd_valid = 1'b0;
      cmd_read = 1'b0;
      cmd_id = 7'h00;
      cmd_ptr = 8'h00;
      cmd_wdata = 8'h00;
      cmd_count = 4'h1;
      failures = 0;
      tests_run = 0;
      max_stall = 0;
      stall_run = 0;
      repeat (3) @(posedge clk);
      #2;
      nrst = 1'b1;
      t_write();
      t_read();
      t_mismatch();
      t_strap();
      t_disable();
      t_stall();
      wrap_up();
   end
endmodule // tb_accel_i2c_slave_port
`default_nettype wire
